//--- verilog/ctl_field_consts.svh
// Purpose: Constants for the link control field codec
// Assumes: Bit n of the field is vector index n-1
// Notes: Leftmost written bit is most significant
`ifndef CTL_FIELD_CONSTS_SVH
`define CTL_FIELD_CONSTS_SVH
`define LOW2_INFO_BIT 1'h0
`define LOW2_SUPV 2'h1
`define LOW2_UNNUM 2'h3
`define PF_POS 8
`define UNNUM_PF_POS 4
`define SEQ_MAX 7'h7f
`define ID_MIN 8'h01
`define DIA_PATTERN 6'h2b
`define DREADY_PATTERN 6'h11
`define DBUSY_PATTERN 6'h15
`define TEST_RSP_PATTERN 8'hf3
`define TOPO_PATTERN 8'h83
`define VREJ_LOW 8'hc3
`define VREJ_GAP 1'h0
`define PREC_URGENT 2'h0
`define PREC_PRIORITY 2'h1
`define PREC_ROUTINE 2'h2
`define PREC_RESERVED 2'h3
`endif

//--- verilog/ctl_field_pkg.sv
// Purpose: Types for the link control field codec
// Assumes: Nothing beyond the constants header
// Notes: Unit class codes are one-hot
package ctl_field_pkg;
  typedef enum logic [6:0] {
    CLS_INFO = 7'h01,
    CLS_SUPV = 7'h02,
    CLS_UNNUM = 7'h04,
    CLS_DIA = 7'h08,
    CLS_DSUPV = 7'h10,
    CLS_TOPO = 7'h20,
    CLS_VREJ = 7'h40
  } unit_class_t;

  typedef struct packed {
    unit_class_t cls;
    logic [5:0] code;
    logic poll_final;
    logic [6:0] send_seq;
    logic [6:0] recv_seq;
    logic [7:0] ident;
    logic [1:0] prec;
    logic is_resp;
    logic [2:0] ver_c;
    logic [2:0] ver_p;
  } ctl_fields_t;
endpackage

//--- verilog/ctl_field_decoder.sv
// Purpose: Classify a received control field into separate fields
// Assumes: Field arrives whole, bit 1 at index 0
// Notes: One-cycle registered output per valid input
`timescale 1ns/1ps
`include "ctl_field_consts.svh"
module ctl_field_decoder
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic in_valid_i,
  input wire logic [15:0] in_field_i,
  output logic out_valid_o,
  output ctl_field_pkg::ctl_fields_t out_fields_o,
  output logic out_error_o
);
  wire logic [15:0] f = in_field_i;
  wire logic is_info = f[0] == `LOW2_INFO_BIT;
  wire logic is_supv = f[1:0] == `LOW2_SUPV;
  wire logic is_dsupv = f[5:4] == 2'h1 && f[1:0] == `LOW2_SUPV;
  wire logic is_dia = f[5:0] == `DIA_PATTERN;
  wire logic is_topo = f[7:0] == `TOPO_PATTERN;
  wire logic is_vrej = f[7:0] == `VREJ_LOW && f[15] == `VREJ_GAP && f[11] == `VREJ_GAP;
  wire logic is_unnum = f[1:0] == `LOW2_UNNUM && !is_dia && !is_topo && !is_vrej;
  wire logic supv_rsvd_bad = f[7:4] != 4'h0;
  wire logic dsupv_known = f[5:0] == `DREADY_PATTERN || f[5:0] == `DBUSY_PATTERN;
  wire logic prec_bad = f[7:6] == `PREC_RESERVED;
  wire logic dsupv_cmd = f[15:8] == 8'h00;
  wire logic id_bad = f[15:8] < `ID_MIN;
  wire logic nxt_error =
    is_dia ? (prec_bad || id_bad) :
    is_dsupv ? (!dsupv_known || prec_bad) :
    is_supv ? supv_rsvd_bad :
    !(is_info || is_unnum || is_topo || is_vrej); // RQ24
  ctl_field_pkg::ctl_fields_t nxt_fields;
  ctl_field_pkg::ctl_fields_t fields_ff;
  logic valid_ff;
  logic error_ff;

  always_comb
  begin
    nxt_fields = '0;
    nxt_fields.cls = ctl_field_pkg::CLS_UNNUM;
    if (is_info)
    begin
      nxt_fields.cls = ctl_field_pkg::CLS_INFO; // RQ3
      nxt_fields.send_seq = f[7:1]; // RQ4
      nxt_fields.recv_seq = f[15:9]; // RQ5
      nxt_fields.poll_final = f[`PF_POS]; // RQ9
    end
    else if (is_dia)
    begin
      nxt_fields.cls = ctl_field_pkg::CLS_DIA; // RQ12
      nxt_fields.ident = f[15:8]; // RQ21
      nxt_fields.prec = f[7:6]; // RQ10
    end
    else if (is_dsupv)
    begin
      nxt_fields.cls = ctl_field_pkg::CLS_DSUPV; // RQ23
      nxt_fields.code = f[5:0]; // RQ13
      nxt_fields.ident = f[15:8]; // RQ14
      nxt_fields.prec = f[7:6];
      nxt_fields.is_resp = !dsupv_cmd; // RQ20
    end
    else if (is_supv)
    begin
      nxt_fields.cls = ctl_field_pkg::CLS_SUPV; // RQ6
      nxt_fields.code = {4'h0, f[3:2]};
      nxt_fields.recv_seq = f[15:9];
      nxt_fields.poll_final = f[`PF_POS];
    end
    else if (is_topo)
    begin
      nxt_fields.cls = ctl_field_pkg::CLS_TOPO; // RQ17
      nxt_fields.ident = f[15:8];
    end
    else if (is_vrej)
    begin
      nxt_fields.cls = ctl_field_pkg::CLS_VREJ;
      nxt_fields.ver_c = f[14:12]; // RQ18
      nxt_fields.ver_p = f[10:8]; // RQ19
    end
    else
    begin
      nxt_fields.code = {f[7:5], f[3:2], 1'h0}; // RQ8
      nxt_fields.poll_final = f[`UNNUM_PF_POS];
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      valid_ff <= 1'h0;
      error_ff <= 1'h0;
      fields_ff <= '0;
    end
    else
    begin
      valid_ff <= in_valid_i; // RQ25
      error_ff <= in_valid_i && nxt_error;
      fields_ff <= in_valid_i ? nxt_fields : fields_ff;
    end
  end

  assign out_valid_o = valid_ff;
  assign out_error_o = error_ff;
  assign out_fields_o = fields_ff;
endmodule

//--- verilog/ctl_field_codec.sv
// Purpose: Build and classify data link control fields
// Assumes: Fields are handled whole; serialising is elsewhere
// Notes: Bit n of a field is index n-1
// How it works
// (RQ1) Leftmost written bit is most significant
// (RQ2) Bit one goes first on the line
// (RQ3) Info unit: bit1 zero, seq, poll, seq
// (RQ4) Send sequence starts at bit two
// (RQ5) Receive sequence starts at bit ten
// (RQ6) Supervisory: 01, code, reserved, poll, seq
// (RQ7) Supervisory reserved bits sent as zero
// (RQ8) Unnumbered: 11, poll bit five, modifiers
// (RQ9) Poll or final set means one
// (RQ10) Precedence: urgent0 priority1 routine2 reserved3
// (RQ11) Test response pattern 11110011
// (RQ12) Decoupled info: id, precedence, 101011
// (RQ13) Decoupled command: zero id, ready/busy pattern
// (RQ14) Decoupled response copies acknowledged id, precedence
// (RQ15) Response goes only to the originator
// (RQ16) Busy station sends the busy form
// (RQ17) Topology update: 10000011 plus identifier
// (RQ18) Reject carries the unprocessable received version
// (RQ19) Reject carries the preferred version
// (RQ20) Decoupled command id bits all zero
// (RQ21) Identification numbers lie in 1..255
// (RQ22) Sequence numbers lie in 0..127
// (RQ23) Decoupled units carry no poll bit
// (RQ24) Undefined or reserved-dirty field flags error
// (RQ25) Decoded fields valid one cycle each
`timescale 1ns/1ps
`include "ctl_field_consts.svh"
module ctl_field_codec
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic enc_valid_i,
  input wire ctl_field_pkg::ctl_fields_t enc_fields_i,
  input wire logic [7:0] enc_dest_i,
  input wire logic station_busy_i,
  output logic enc_valid_o,
  output logic [15:0] enc_field_o,
  output logic enc_wide_o,
  output logic [7:0] enc_dest_o,
  output logic enc_error_o,
  input wire logic dec_valid_i,
  input wire logic [15:0] dec_field_i,
  output logic dec_valid_o,
  output ctl_field_pkg::ctl_fields_t dec_fields_o,
  output logic dec_error_o
);
  wire ctl_field_pkg::ctl_fields_t e = enc_fields_i;
  wire logic [15:0] info_word = {e.recv_seq, e.poll_final, e.send_seq, `LOW2_INFO_BIT}; // RQ3
  wire logic [15:0] supv_word = {e.recv_seq, e.poll_final, 4'h0, e.code[1:0], `LOW2_SUPV}; // RQ7
  wire logic [15:0] unnum_word = {8'h00, e.code[5:3], e.poll_final, e.code[2:1], `LOW2_UNNUM}; // RQ8
  wire logic [15:0] dia_word = {e.ident, e.prec, `DIA_PATTERN}; // RQ12
  wire logic [5:0] dsupv_pat = station_busy_i ? `DBUSY_PATTERN : `DREADY_PATTERN; // RQ16
  wire logic [7:0] dsupv_id = e.is_resp ? e.ident : 8'h00; // RQ20
  wire logic [15:0] dsupv_word = {dsupv_id, e.prec, dsupv_pat}; // RQ14
  wire logic [15:0] topo_word = {e.ident, `TOPO_PATTERN}; // RQ17
  wire logic [15:0] vrej_word = {`VREJ_GAP, e.ver_c, `VREJ_GAP, e.ver_p, `VREJ_LOW}; // RQ18
  wire logic prec_bad = e.prec == `PREC_RESERVED; // RQ10
  wire logic id_bad = e.ident < `ID_MIN; // RQ21
  wire logic seq_bad = e.send_seq > `SEQ_MAX || e.recv_seq > `SEQ_MAX; // RQ22
  logic [15:0] nxt_field;
  logic nxt_wide;
  logic nxt_err;
  logic [15:0] field_ff;
  logic wide_ff;
  logic valid_ff;
  logic err_ff;
  logic [7:0] dest_ff;

  always_comb
  begin
    nxt_field = 16'h0000;
    nxt_wide = 1'h1;
    nxt_err = 1'h0;
    unique case (e.cls)
      ctl_field_pkg::CLS_INFO:
      begin
        nxt_field = info_word;
        nxt_err = seq_bad;
      end
      ctl_field_pkg::CLS_SUPV:
      begin
        nxt_field = supv_word; // RQ6
        nxt_err = seq_bad;
      end
      ctl_field_pkg::CLS_UNNUM:
      begin
        nxt_field = unnum_word; // RQ11
        nxt_wide = 1'h0;
      end
      ctl_field_pkg::CLS_DIA:
      begin
        nxt_field = dia_word; // RQ23
        nxt_err = prec_bad || id_bad;
      end
      ctl_field_pkg::CLS_DSUPV:
      begin
        nxt_field = dsupv_word; // RQ13
        nxt_err = prec_bad || (e.is_resp && id_bad);
      end
      ctl_field_pkg::CLS_TOPO:
        nxt_field = topo_word;
      ctl_field_pkg::CLS_VREJ:
        nxt_field = vrej_word; // RQ19
      default:
        nxt_err = 1'h1;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (reset_i)
    begin
      valid_ff <= 1'h0;
      err_ff <= 1'h0;
      field_ff <= 16'h0000;
      wide_ff <= 1'h0;
      dest_ff <= 8'h00;
    end
    else
    begin
      valid_ff <= enc_valid_i;
      err_ff <= enc_valid_i && nxt_err;
      if (enc_valid_i)
      begin
        field_ff <= nxt_field; // RQ1
        wide_ff <= nxt_wide;
        dest_ff <= enc_dest_i; // RQ15
      end
    end
  end

  assign enc_valid_o = valid_ff;
  assign enc_error_o = err_ff;
  assign enc_field_o = field_ff; // RQ2
  assign enc_wide_o = wide_ff;
  assign enc_dest_o = dest_ff;

  ctl_field_decoder u_dec
  (
    .core_clk_i(core_clk_i),
    .reset_i(reset_i),
    .in_valid_i(dec_valid_i),
    .in_field_i(dec_field_i),
    .out_valid_o(dec_valid_o),
    .out_fields_o(dec_fields_o),
    .out_error_o(dec_error_o)
  );
endmodule

//--- verif/ctl_field_codec_props.sv
// Purpose: Port assertions for the codec
// Assumes: Encoder answers one cycle after request
// Notes: Bound to the codec
`timescale 1ns/1ps
module ctl_field_codec_props
(
  input wire logic core_clk_i,
  input wire logic reset_i,
  input wire logic enc_valid_i,
  input wire ctl_field_pkg::ctl_fields_t enc_fields_i,
  input wire logic [7:0] enc_dest_i,
  input wire logic station_busy_i,
  input wire logic enc_valid_o,
  input wire logic [15:0] enc_field_o,
  input wire logic [7:0] enc_dest_o,
  input wire logic enc_error_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  sequence req(logic [6:0] c);
    enc_valid_i && enc_fields_i.cls == c;
  endsequence
  a_info_send_seq: assert property (req(7'h01) |=>
    enc_field_o[7:0] == {$past(enc_fields_i.send_seq), 1'h0}) else $error("info send bad");
  a_info_recv_seq: assert property (req(7'h01) |=>
    enc_field_o[15:8] == {$past(enc_fields_i.recv_seq), $past(enc_fields_i.poll_final)}) else $error("info recv bad");
  a_supv_zero_resv: assert property (req(7'h02) |=>
    enc_field_o[7:4] == 4'h0 && enc_field_o[1:0] == 2'h1) else $error("supv bad");
  a_dia_pattern: assert property (req(7'h08) |=>
    enc_field_o[7:0] == {$past(enc_fields_i.prec), 6'h2b}) else $error("dia bad");
  a_busy_form: assert property (req(7'h10) ##0 station_busy_i |=>
    enc_field_o[5:0] == 6'h15) else $error("busy bad");
  a_topo_pattern: assert property (req(7'h20) |=>
    enc_field_o == {$past(enc_fields_i.ident), 8'h83}) else $error("topo bad");
  a_prec_reserved: assert property (req(7'h08) ##0 enc_fields_i.prec == 2'h3 |=>
    enc_error_o) else $error("prec not flagged");
  a_vrej_layout: assert property (req(7'h40) |=>
    enc_field_o == {1'h0, $past(enc_fields_i.ver_c), 1'h0, $past(enc_fields_i.ver_p), 8'hc3}) else $error("vrej bad");
  a_dest_copy: assert property (enc_valid_i |=>
    enc_valid_o && enc_dest_o == $past(enc_dest_i)) else $error("dest bad");
endmodule

bind ctl_field_codec ctl_field_codec_props props_i
(
  .core_clk_i(core_clk_i), .reset_i(reset_i), .enc_valid_i(enc_valid_i), .enc_fields_i(enc_fields_i),
  .enc_dest_i(enc_dest_i), .station_busy_i(station_busy_i), .enc_valid_o(enc_valid_o),
  .enc_field_o(enc_field_o), .enc_dest_o(enc_dest_o), .enc_error_o(enc_error_o)
);

//--- verif/remote_station_model.sv
// Purpose: Remote station echoing fields back
// Assumes: Field whole, bit 1 at index 0
// Notes: Bench may inject a raw field
`timescale 1ns/1ps
module remote_station_model
(
  input wire logic core_clk_i,
  input wire logic rx_valid_i,
  input wire logic [15:0] rx_field_i,
  input wire logic inj_valid_i,
  input wire logic [15:0] inj_field_i,
  output logic tx_valid_o = 1'h0,
  output logic [15:0] tx_field_o = 16'h0
);
  always @(posedge core_clk_i)
  begin
    tx_valid_o <= rx_valid_i | inj_valid_i;
    tx_field_o <= inj_valid_i ? inj_field_i : rx_valid_i ? rx_field_i : ~tx_field_o;
  end
endmodule

//--- verif/link_pdu_control_field_codec_bench.sv
// Purpose: Self-checking bench for the codec
// Assumes: Remote model loops encoded fields back
// Notes: Notes queued by driver, popped by watcher
`timescale 1ns/1ps
module link_pdu_control_field_codec_bench;
  logic core_clk_i = 1'h0, reset_i = 1'h1, enc_valid_i = 1'h0, station_busy_i = 1'h0, inj_valid = 1'h0;
  ctl_field_pkg::ctl_fields_t enc_fields_i = '0, dec_fields_o;
  logic [7:0] enc_dest_i = 8'h0, enc_dest_o;
  logic [15:0] inj_field = 16'h0, enc_field_o, dec_field_i;
  logic enc_valid_o, enc_wide_o, enc_error_o, dec_valid_i, dec_valid_o, dec_error_o;
  logic [17:0] enc_q[$];
  logic [8:0] dec_q[$];
  logic [8:0] n;
  logic [31:0] seed = 32'h172aa387;
  int fail_count = 0, total_checks = 0;
  always #2 core_clk_i = ~core_clk_i;
  ctl_field_codec dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .enc_valid_i(enc_valid_i),
    .enc_fields_i(enc_fields_i), .enc_dest_i(enc_dest_i), .station_busy_i(station_busy_i),
    .enc_valid_o(enc_valid_o), .enc_field_o(enc_field_o), .enc_wide_o(enc_wide_o), .enc_dest_o(enc_dest_o),
    .enc_error_o(enc_error_o), .dec_valid_i(dec_valid_i), .dec_field_i(dec_field_i),
    .dec_valid_o(dec_valid_o), .dec_fields_o(dec_fields_o), .dec_error_o(dec_error_o));
  remote_station_model far (.core_clk_i(core_clk_i), .rx_valid_i(enc_valid_o & ~enc_error_o),
    .rx_field_i(enc_field_o), .inj_valid_i(inj_valid), .inj_field_i(inj_field),
    .tx_valid_o(dec_valid_i), .tx_field_o(dec_field_i));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(string what, logic [17:0] exp, logic [17:0] got);
    total_checks++;
    if (exp !== got)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic send(ctl_field_pkg::ctl_fields_t f, logic [15:0] x, logic w, logic e, logic lb);
    @(posedge core_clk_i);
    #1;
    enc_valid_i = 1'h1;
    enc_fields_i = f;
    enc_dest_i = seed[7:0];
    enc_q.push_back({e, w, x});
    if (lb && !e)
      dec_q.push_back({2'h2, f.cls});
  endtask
  task automatic idle(string name);
    @(posedge core_clk_i);
    #1;
    enc_valid_i = 1'h0;
    inj_valid = 1'h0;
    repeat (4) @(posedge core_clk_i);
    check("pending", 18'h0, 18'(enc_q.size() + dec_q.size()));
    $display("done %s", name);
  endtask
  task print_verdict();
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(negedge core_clk_i)
  begin
    if (enc_valid_o !== 1'h0)
      check("enc", enc_q.size() ? enc_q.pop_front() : 18'h3ffff, {enc_error_o, enc_wide_o, enc_field_o});
    if (dec_valid_o !== 1'h0)
    begin
      n = dec_q.size() ? dec_q.pop_front() : 9'h1ff;
      check("dec", n, {n[8], dec_error_o, n[8] ? dec_fields_o.cls : n[6:0]});
    end
  end
  initial
  begin
    #20000;
    fail_count++;
    print_verdict();
  end
  initial
  begin
    logic [31:0] x;
    static logic [5:0] uc[4] = '{6'h00, 6'h04, 6'h08, 6'h38};
    repeat (6) @(posedge core_clk_i);
    #1;
    reset_i = 1'h0;
    for (int k = 0; k < 8; k++)
    begin
      x = rnd();
      send('{ctl_field_pkg::CLS_INFO, 6'h0, x[7], x[6:0], x[14:8], 8'h0, 2'h0, 1'h0, 3'h0, 3'h0},
        {x[14:8], x[7], x[6:0], 1'h0}, 1'h1, 1'h0, 1'h1);
      send('{ctl_field_pkg::CLS_SUPV, {4'h0, x[1:0]}, x[7], 7'h0, x[14:8], 8'h0, 2'h0, 1'h0, 3'h0, 3'h0},
        {x[14:8], x[7], 4'h0, x[1:0], 2'h1}, 1'h1, 1'h0, 1'h1);
      send('{ctl_field_pkg::CLS_UNNUM, uc[k%4], x[7], 7'h0, 7'h0, 8'h0, 2'h0, 1'h0, 3'h0, 3'h0},
        {8'h0, uc[k%4][5:3], x[7], uc[k%4][2:1], 2'h3}, 1'h0, 1'h0, 1'h1);
      send('{ctl_field_pkg::CLS_DIA, 6'h2b, 1'h0, 7'h0, 7'h0, x[23:16], k[1:0], 1'h0, 3'h0, 3'h0},
        {x[23:16], k[1:0], 6'h2b}, 1'h1, k[1:0] == 2'h3 || x[23:16] == 8'h0, 1'h1);
      station_busy_i = k[0];
      send('{ctl_field_pkg::CLS_DSUPV, 6'h0, 1'h1, 7'h0, 7'h0, x[23:16] | 8'h1, x[25:24] & 2'h1, k[1], 3'h0, 3'h0},
        {k[1] ? x[23:16] | 8'h1 : 8'h0, x[25:24] & 2'h1, k[0] ? 6'h15 : 6'h11}, 1'h1, 1'h0, 1'h1);
      send('{ctl_field_pkg::CLS_TOPO, 6'h0, 1'h0, 7'h0, 7'h0, x[31:24] & 8'h3f, 2'h0, 1'h0, 3'h0, 3'h0},
        {x[31:24] & 8'h3f, 8'h83}, 1'h1, 1'h0, 1'h1);
      send('{ctl_field_pkg::CLS_VREJ, 6'h0, 1'h0, 7'h0, 7'h0, 8'h0, 2'h0, 1'h0, x[2:0], x[5:3]},
        {1'h0, x[2:0], 1'h0, x[5:3], 8'hc3}, 1'h1, 1'h0, 1'h1);
    end
    idle("encode");
    @(posedge core_clk_i);
    #1;
    inj_valid = 1'h1;
    inj_field = 16'h011d;
    dec_q.push_back(9'h080);
    @(posedge core_clk_i);
    #1;
    inj_field = 16'h0081;
    dec_q.push_back(9'h080);
    idle("decode errors");
    print_verdict();
  end
endmodule
